// *** common/mcg_pkg.sv ***
package mcg_pkg;

    // Bus geometry.
    localparam int          DATA_W              = 32;
    localparam int          ADDR_W              = 16;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDLE_CFG_IDX        = 16'h0001;
    localparam logic [15:0] PCG_CTRL_IDX        = 16'h1c02;
    localparam logic [15:0] WAKE_CFG_IDX        = 16'h0010;
    localparam logic [15:0] IDLE_CMD_IDX        = 16'h0011;

    // Field positions.
    localparam int          GATE_BIT            = 15;
    localparam int          PERIPH_W            = 15;
    localparam int          RTC_ALARM_EN_BIT    = 0;
    localparam int          RTC_PERIODIC_EN_BIT = 1;
    localparam int          IDLE_GO_BIT         = 0;
    localparam int          PIN_STATUS_LSB      = 8;
    localparam int          WAKE_ACTIVE_BIT     = 13;

    // Reset values: master clock running, every peripheral clock disabled.
    localparam logic [15:0] PCG_CTRL_RESET      = 16'h7fff;
    localparam logic [15:0] IDLE_CFG_RESET      = 16'h0000;
    localparam logic [15:0] WAKE_CFG_RESET      = 16'h0000;
    localparam logic [15:0] DOMAIN_IDLE_RESET   = 16'h0000;

    // AXI responses.
    localparam logic [1:0]  RESP_OKAY           = 2'b00;
    localparam logic [1:0]  RESP_SLVERR         = 2'b10;

    typedef enum logic [0:0] {
        MCG_WR_IDLE = 1'b0,
        MCG_WR_RESP = 1'b1
    } mcg_wr_state_t;

    typedef enum logic [0:0] {
        MCG_RD_IDLE = 1'b0,
        MCG_RD_DATA = 1'b1
    } mcg_rd_state_t;

    // Wake sources as they arrive at the block boundary.
    typedef struct packed {
        logic irq_zero_n;
        logic ext_irq_one_pin;
        logic wake_request_pin;
        logic rtc_alarm;
        logic rtc_periodic;
    } mcg_wake_src_t;

endpackage : mcg_pkg

// *** rtl/mcg_clock_gate.sv ***
// Summary of operation
// RQ1: Writing one to gate bit 15 of the clock gating register stops the master clock.
// RQ2: Hardware reset clears the gate bit and restarts the master clock.
// RQ3: An enabled real-time-clock alarm or periodic event clears the gate bit.
// RQ4: A low level on either interrupt pin clears the gate bit.
// RQ5: A high level on the wake pin clears the gate bit.
// RQ6: Asserted pin levels force the gate bit to zero, enabling the master clock.
// RQ7: Setting the gate bit while any wake source is asserted has no effect.
// RQ8: The outside system holds the wake pin low for clock stopping to work.
// RQ9: After reset every peripheral clock stays off until software enables it.
// RQ10: Software writes the idle configuration then issues idle to idle the configured domains.
// RQ11: Reading the gate bit returns its current state, including forced clears.
module mcg_clock_gate (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic                            ce,
    input  wire logic [mcg_pkg::ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [mcg_pkg::DATA_W-1:0]      s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [mcg_pkg::ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [mcg_pkg::DATA_W-1:0]           s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire mcg_pkg::mcg_wake_src_t          wake_src,
    output logic                                 master_clk_en,
    output logic [mcg_pkg::PERIPH_W-1:0]         periph_clk_en,
    output logic [15:0]                          domain_idle
);

    // Byte address of a register index.
    function automatic logic [15:0] reg_addr(input logic [15:0] idx);
        reg_addr = {idx[13:0], 2'b00};
    endfunction : reg_addr

    // True when an address selects a mapped register.
    function automatic logic addr_hit(input logic [15:0] addr);
        addr_hit = (addr == reg_addr(mcg_pkg::IDLE_CFG_IDX)) || (addr == reg_addr(mcg_pkg::PCG_CTRL_IDX)) ||
                   (addr == reg_addr(mcg_pkg::WAKE_CFG_IDX)) || (addr == reg_addr(mcg_pkg::IDLE_CMD_IDX));
    endfunction : addr_hit

    // Merges the low two byte lanes of a write into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge16

    mcg_pkg::mcg_wake_src_t wake_sync;
    logic                   wake_any;

    // Every wake source crosses into the clock domain through two flops.
    mcg_sync #(
        .W         (5),
        .RESET_VAL (5'h18)
    ) u_wake_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .async_in (wake_src),
        .sync_out (wake_sync)
    );

    logic [15:0] pcg_reg;
    logic [15:0] pcg_next;
    logic [15:0] idle_cfg_reg;
    logic [15:0] idle_cfg_next;
    logic [15:0] wake_cfg_reg;
    logic [15:0] wake_cfg_next;
    logic [15:0] domain_idle_reg;
    logic [15:0] domain_idle_next;
    logic        master_clk_en_reg;
    logic        master_clk_en_next;
    logic [14:0] periph_clk_en_reg;
    logic [14:0] periph_clk_en_next;

    mcg_pkg::mcg_wr_state_t wr_state_reg;
    mcg_pkg::mcg_wr_state_t wr_state_next;
    logic        aw_held_reg;
    logic        aw_held_next;
    logic        w_held_reg;
    logic        w_held_next;
    logic [15:0] awaddr_reg;
    logic [15:0] awaddr_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0]  wstrb_reg;
    logic [3:0]  wstrb_next;
    logic        awready_reg;
    logic        awready_next;
    logic        wready_reg;
    logic        wready_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        do_write;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;

    mcg_pkg::mcg_rd_state_t rd_state_reg;
    mcg_pkg::mcg_rd_state_t rd_state_next;
    logic        arready_reg;
    logic        arready_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;

    // Any asserted wake source: interrupt pins low, wake pin high, enabled RTC events.
    assign wake_any = !wake_sync.irq_zero_n || !wake_sync.ext_irq_one_pin      // see RQ4
                   || wake_sync.wake_request_pin                              // see RQ5
                   || (wake_sync.rtc_alarm && wake_cfg_reg[mcg_pkg::RTC_ALARM_EN_BIT])        // see RQ3
                   || (wake_sync.rtc_periodic && wake_cfg_reg[mcg_pkg::RTC_PERIODIC_EN_BIT]);

    // Write channel: address and data are taken in either order, then one response.
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_held_next  = aw_held_reg;
        w_held_next   = w_held_reg;
        awaddr_next   = awaddr_reg;
        wdata_next    = wdata_reg;
        wstrb_next    = wstrb_reg;
        awready_next  = awready_reg;
        wready_next   = wready_reg;
        bvalid_next   = bvalid_reg;
        bresp_next    = bresp_reg;
        do_write      = 1'b0;
        wr_addr       = aw_held_reg ? awaddr_reg : s_axi_awaddr;
        wr_data       = w_held_reg ? wdata_reg : s_axi_wdata;
        wr_strb       = w_held_reg ? wstrb_reg : s_axi_wstrb;
        case (wr_state_reg)
            mcg_pkg::MCG_WR_IDLE: begin
                if (s_axi_awvalid && awready_reg) begin
                    aw_held_next = 1'b1;
                    awaddr_next  = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_reg) begin
                    w_held_next = 1'b1;
                    wdata_next  = s_axi_wdata;
                    wstrb_next  = s_axi_wstrb;
                end
                if (aw_held_next && w_held_next) begin
                    do_write      = 1'b1;
                    aw_held_next  = 1'b0;
                    w_held_next   = 1'b0;
                    awready_next  = 1'b0;
                    wready_next   = 1'b0;
                    bvalid_next   = 1'b1;
                    bresp_next    = addr_hit(wr_addr) ? mcg_pkg::RESP_OKAY : mcg_pkg::RESP_SLVERR;
                    wr_state_next = mcg_pkg::MCG_WR_RESP;
                end else begin
                    awready_next = !aw_held_next;
                    wready_next  = !w_held_next;
                end
            end
            mcg_pkg::MCG_WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_next   = 1'b0;
                    awready_next  = 1'b1;
                    wready_next   = 1'b1;
                    wr_state_next = mcg_pkg::MCG_WR_IDLE;
                end
            end
            default: begin
                wr_state_next = mcg_pkg::MCG_WR_IDLE;
            end
        endcase
    end

    // Register file and the clock gate: a wake source overrides a software set.
    always_comb begin
        pcg_next         = pcg_reg;
        idle_cfg_next    = idle_cfg_reg;
        wake_cfg_next    = wake_cfg_reg;
        domain_idle_next = domain_idle_reg;
        if (do_write) begin
            if (wr_addr == reg_addr(mcg_pkg::PCG_CTRL_IDX)) begin
                pcg_next = merge16(pcg_reg, wr_data, wr_strb);                // see RQ1
            end else if (wr_addr == reg_addr(mcg_pkg::IDLE_CFG_IDX)) begin
                idle_cfg_next = merge16(idle_cfg_reg, wr_data, wr_strb);
            end else if (wr_addr == reg_addr(mcg_pkg::WAKE_CFG_IDX)) begin
                wake_cfg_next = merge16(wake_cfg_reg, wr_data, wr_strb);
            end else if (wr_addr == reg_addr(mcg_pkg::IDLE_CMD_IDX)) begin
                if (wr_strb[0] && wr_data[mcg_pkg::IDLE_GO_BIT]) begin
                    domain_idle_next = idle_cfg_reg;                          // see RQ10
                end
            end
        end
        if (wake_any) begin
            pcg_next[mcg_pkg::GATE_BIT] = 1'b0;                               // see RQ6, see RQ7
        end
        master_clk_en_next = !pcg_next[mcg_pkg::GATE_BIT];
        periph_clk_en_next = ~pcg_next[mcg_pkg::PERIPH_W-1:0];
    end

    // Read channel: one read at a time, data registered one cycle after the address.
    always_comb begin
        rd_state_next = rd_state_reg;
        arready_next  = arready_reg;
        rvalid_next   = rvalid_reg;
        rdata_next    = rdata_reg;
        rresp_next    = rresp_reg;
        case (rd_state_reg)
            mcg_pkg::MCG_RD_IDLE: begin
                arready_next = 1'b1;
                if (s_axi_arvalid && arready_reg) begin
                    arready_next  = 1'b0;
                    rvalid_next   = 1'b1;
                    rresp_next    = mcg_pkg::RESP_OKAY;
                    rdata_next    = '0;
                    rd_state_next = mcg_pkg::MCG_RD_DATA;
                    if (s_axi_araddr == reg_addr(mcg_pkg::PCG_CTRL_IDX)) begin
                        rdata_next[15:0] = pcg_reg;                            // see RQ11
                    end else if (s_axi_araddr == reg_addr(mcg_pkg::IDLE_CFG_IDX)) begin
                        rdata_next[15:0] = idle_cfg_reg;
                    end else if (s_axi_araddr == reg_addr(mcg_pkg::WAKE_CFG_IDX)) begin
                        rdata_next[15:0] = wake_cfg_reg & 16'h0003;
                        rdata_next[mcg_pkg::PIN_STATUS_LSB +: 5] = wake_sync;
                        rdata_next[mcg_pkg::WAKE_ACTIVE_BIT] = wake_any;
                    end else if (s_axi_araddr == reg_addr(mcg_pkg::IDLE_CMD_IDX)) begin
                        rdata_next[15:0] = domain_idle_reg;
                    end else begin
                        rresp_next = mcg_pkg::RESP_SLVERR;
                    end
                end
            end
            mcg_pkg::MCG_RD_DATA: begin
                if (s_axi_rready) begin
                    rvalid_next   = 1'b0;
                    arready_next  = 1'b1;
                    rd_state_next = mcg_pkg::MCG_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = mcg_pkg::MCG_RD_IDLE;
            end
        endcase
    end

    // State registers; reset wins over the clock enable and restarts the clock.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcg_reg           <= mcg_pkg::PCG_CTRL_RESET;                     // see RQ2, see RQ9
            idle_cfg_reg      <= mcg_pkg::IDLE_CFG_RESET;
            wake_cfg_reg      <= mcg_pkg::WAKE_CFG_RESET;
            domain_idle_reg   <= mcg_pkg::DOMAIN_IDLE_RESET;
            master_clk_en_reg <= 1'b1;
            periph_clk_en_reg <= '0;
            wr_state_reg      <= mcg_pkg::MCG_WR_IDLE;
            aw_held_reg       <= 1'b0;
            w_held_reg        <= 1'b0;
            awaddr_reg        <= '0;
            wdata_reg         <= '0;
            wstrb_reg         <= '0;
            awready_reg       <= 1'b0;
            wready_reg        <= 1'b0;
            bvalid_reg        <= 1'b0;
            bresp_reg         <= mcg_pkg::RESP_OKAY;
            rd_state_reg      <= mcg_pkg::MCG_RD_IDLE;
            arready_reg       <= 1'b0;
            rvalid_reg        <= 1'b0;
            rdata_reg         <= '0;
            rresp_reg         <= mcg_pkg::RESP_OKAY;
        end else if (ce) begin
            pcg_reg           <= pcg_next;
            idle_cfg_reg      <= idle_cfg_next;
            wake_cfg_reg      <= wake_cfg_next;
            domain_idle_reg   <= domain_idle_next;
            master_clk_en_reg <= master_clk_en_next;
            periph_clk_en_reg <= periph_clk_en_next;
            wr_state_reg      <= wr_state_next;
            aw_held_reg       <= aw_held_next;
            w_held_reg        <= w_held_next;
            awaddr_reg        <= awaddr_next;
            wdata_reg         <= wdata_next;
            wstrb_reg         <= wstrb_next;
            awready_reg       <= awready_next;
            wready_reg        <= wready_next;
            bvalid_reg        <= bvalid_next;
            bresp_reg         <= bresp_next;
            rd_state_reg      <= rd_state_next;
            arready_reg       <= arready_next;
            rvalid_reg        <= rvalid_next;
            rdata_reg         <= rdata_next;
            rresp_reg         <= rresp_next;
        end
    end

    // Outputs come straight from flops.
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign master_clk_en = master_clk_en_reg;
    assign periph_clk_en = periph_clk_en_reg;
    assign domain_idle   = domain_idle_reg;

    // A software set with no wake source stops the master clock on the next edge.
    gate_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ1
        ce && do_write && wr_addr == reg_addr(mcg_pkg::PCG_CTRL_IDX) && wr_strb[1] && wr_data[15] && !wake_any
        |=> pcg_reg[15] && !master_clk_en_reg)
        else $error("Gate write did not stop the master clock.");

    // Reset always leaves the master clock running.
    reset_restart_a: assert property (@(posedge aclk) // see RQ2
        !aresetn |=> master_clk_en_reg && !pcg_reg[15])
        else $error("Reset did not restart the master clock.");

    // An enabled RTC alarm clears the gate bit.
    rtc_wake_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ3
        ce && wake_sync.rtc_alarm && wake_cfg_reg[0] |=> !pcg_reg[15] && master_clk_en_reg)
        else $error("Enabled RTC alarm did not restart the clock.");

    // A low interrupt level keeps the clock running.
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ4
        ce && (!wake_sync.irq_zero_n || !wake_sync.ext_irq_one_pin) |=> master_clk_en_reg)
        else $error("Interrupt level did not restart the clock.");

    // A high wake level keeps the gate bit clear.
    wake_level_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ5
        ce && wake_sync.wake_request_pin |=> !pcg_reg[15])
        else $error("Wake level did not clear the gate bit.");

    // Three enabled cycles of a raw wake level reach the clock enable one edge later.
    pin_to_clock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ6
        (ce && wake_src.wake_request_pin)[*3] |-> ##1 master_clk_en_reg)
        else $error("Raw wake pin did not enable the clock in time.");

    // A set attempt while a wake source is asserted is lost.
    set_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ7
        ce && do_write && wr_addr == reg_addr(mcg_pkg::PCG_CTRL_IDX) && wake_any |=> !pcg_reg[15])
        else $error("Gate set succeeded while a wake source was asserted.");

    // Peripheral clocks are off right after reset release.
    periph_off_a: assert property (@(posedge aclk) // see RQ9
        $rose(aresetn) |-> periph_clk_en_reg == 15'h0000 && domain_idle_reg == 16'h0000)
        else $error("Peripheral clocks not off after reset.");

    // A read of the gating register returns the value held at the address phase.
    read_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ11
        ce && s_axi_arvalid && arready_reg && s_axi_araddr == reg_addr(mcg_pkg::PCG_CTRL_IDX)
        |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(pcg_reg))
        else $error("Gate register read returned a stale value.");

endmodule : mcg_clock_gate

// *** rtl/mcg_sync.sv ***
// Two-stage synchroniser; only the second stage is visible outside.
module mcg_sync #(
    parameter int              W         = 5,
    parameter logic [W-1:0]    RESET_VAL = '0
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    input  wire logic [W-1:0]  async_in,
    output logic      [W-1:0]  sync_out
);

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage1_next;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage2_next;

    // The first stage feeds the second stage and nothing else.
    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    // Both stages freeze while the clock enable is low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
        end else if (ce) begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;

endmodule : mcg_sync

// *** tb/master_clock_gate_wake_tb_top.sv ***
module master_clock_gate_wake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PCG_A = {mcg_pkg::PCG_CTRL_IDX[13:0], 2'b00};
    localparam logic [15:0] IDLE_A = {mcg_pkg::IDLE_CFG_IDX[13:0], 2'b00};
    localparam logic [15:0] WAKE_A = {mcg_pkg::WAKE_CFG_IDX[13:0], 2'b00};
    localparam logic [15:0] CMD_A = {mcg_pkg::IDLE_CMD_IDX[13:0], 2'b00};
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, master_clk_en;
    logic [15:0] awaddr, araddr, domain_idle;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [4:0] req;
    logic [14:0] periph_clk_en;
    mcg_pkg::mcg_wake_src_t wake_src;
    int bad_count, compares, cyc;

    mcg_wake_model wm (.req(req), .wake_src(wake_src));
    mcg_clock_gate uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_src(wake_src),
        .master_clk_en(master_clk_en), .periph_clk_en(periph_clk_en), .domain_idle(domain_idle));

    // Clock of 5 ns period.
    always #2.5 aclk = ~aclk;

    // Cut a hang short.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Waits 1 ns, then compares the value copied in when the task was called.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        #1;
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One AXI-Lite write; address and data offered together, each released when taken.
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, v};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask : wr

    // One AXI-Lite read.
    task automatic rd(input logic [15:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd

    // Stops the master clock with a gate write and checks that it stopped.
    task automatic gate();
        wr(PCG_A, 16'hffff);
        chk("master_clk_en gated", 32'h0, master_clk_en);
    endtask : gate

    task automatic settle();
        repeat (5) @(posedge aclk);
    endtask : settle

    // Main sequence.
    initial begin
        aclk = 0; aresetn = 0; ce = 1; req = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk("master_clk_en", 32'h1, master_clk_en);
        chk("periph_clk_en", 32'h0, periph_clk_en);
        rd(PCG_A);
        chk("pcg reset", 32'h7fff, d);
        wr(PCG_A, 16'h7ff0);
        chk("periph_clk_en", 32'h000f, periph_clk_en);
        $display("test reset and peripherals done");
        gate();
        @(posedge aclk);
        req <= 5'b00011;
        settle();
        req <= 5'b00000;
        chk("rtc disabled", 32'h0, master_clk_en);
        wr(WAKE_A, 16'h0003);
        rd(WAKE_A);
        chk("wake cfg", 32'h0003, d[1:0]);
        $display("test rtc enables done");
        for (int i = 0; i < 5; i++) begin
            gate();
            @(posedge aclk);
            req <= 5'b00001 << i;
            settle();
            chk("master_clk_en woken", 32'h1, master_clk_en);
            rd(PCG_A);
            chk("pcg after wake", 32'h7fff, d);
            rd(WAKE_A);
            chk("wake status", 32'h2003 | (((32'h1 << i) ^ 32'h18) << 8), d);
            wr(PCG_A, 16'hfff0);
            chk("bresp", 32'h0, r);
            rd(PCG_A);
            chk("pcg set refused", 32'h7ff0, d);
            chk("periph low bits landed", 32'h000f, periph_clk_en);
            chk("master_clk_en held", 32'h1, master_clk_en);
            @(posedge aclk);
            req <= 5'b00000;
            settle();
        end
        $display("test wake sources done");
        gate();
        @(posedge aclk);
        ce <= 1'b0;
        req <= 5'b00100;
        settle();
        chk("master_clk_en frozen", 32'h0, master_clk_en);
        @(posedge aclk);
        ce <= 1'b1;
        settle();
        chk("master_clk_en after ce", 32'h1, master_clk_en);
        @(posedge aclk);
        req <= 5'b00000;
        settle();
        $display("test clock enable done");
        gate();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("master_clk_en reset", 32'h1, master_clk_en);
        chk("periph reset", 32'h0, periph_clk_en);
        rd(PCG_A);
        chk("pcg reset", 32'h7fff, d);
        $display("test reset while gated done");
        wr(IDLE_A, 16'h000e);
        chk("domain_idle early", 32'h0, domain_idle);
        wr(CMD_A, 16'h0001);
        chk("domain_idle", 32'h000e, domain_idle);
        wr(16'h0008, 16'h1234);
        chk("bresp unmapped", 32'h2, r);
        rd(16'h0008);
        chk("rresp unmapped", 32'h2, r);
        chk("rdata unmapped", 32'h0, d);
        $display("test idle and unmapped done");
        results();
    end
endmodule : master_clock_gate_wake_tb_top

// *** tb/mcg_wake_model.sv ***
// Far-side wake sources: each request bit drives its pin to its active level, otherwise the inactive level.
module mcg_wake_model (
    input  wire logic [4:0]         req,
    output mcg_pkg::mcg_wake_src_t  wake_src
);
    timeunit 1ns;
    timeprecision 1ps;

    // Map request bits onto pin polarities; an idle wake pin is held low so the clock can stop.
    always_comb begin
        wake_src.irq_zero_n       = ~req[4];
        wake_src.ext_irq_one_pin  = ~req[3];
        wake_src.wake_request_pin = req[2];
        wake_src.rtc_alarm        = req[1];
        wake_src.rtc_periodic     = req[0];
    end
endmodule : mcg_wake_model
